// ### design/dfre_exec.sv
// execution of the decrement-file instruction over one four-phase cycle
// assumes the sequencer presents a new word each Q1 and the file memory
// answers a read address with data in the same cycle
`timescale 1ns/1ps
`default_nettype none
module dfre_exec
  import dfre_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  // from the fetch sequencer
  input  wire logic        INSTR_VALID_I,
  input  wire logic [13:0] INSTR_I,
  // file memory read port
  input  wire logic [7:0]  FILE_RDATA_I,
  output logic      [6:0]  FILE_RADDR_O,
  output logic             FILE_RE_O,
  // file memory write port
  output logic             FILE_WE_O,
  output logic      [6:0]  FILE_WADDR_O,
  output logic      [7:0]  FILE_WDATA_O,
  // accumulator and status
  output logic      [7:0]  W_O,
  output logic             ZERO_FLAG_O,
  output logic             ZERO_WE_O,
  // sequencing
  output logic      [1:0]  PHASE_O,
  output logic             DONE_O
);
  // phase of the four-phase instruction cycle
  dfre_phase_type phase_q, phase_d;
  // decoded word held from q1 until the next q1 ends, read address until the next word is taken; the read strobe stands in q2 only
  dfre_dec_type   dec_w;
  dfre_dec_type   dec_q, dec_d;
  logic           re_q, re_d;
  logic [6:0]     raddr_q, raddr_d;
  // datapath operand and result
  logic [7:0]     opnd_q, opnd_d;
  logic [7:0]     res_q, res_d;
  // destination side: accumulator and file write request
  logic [7:0]     w_q, w_d;
  dfre_wr_type    wr_q, wr_d;
  // status and retire
  logic           z_q, z_d;
  logic           zwe_q, zwe_d;
  logic           done_q, done_d;
  // qualifiers shared by the groups below
  logic           take_w;
  logic           retire_w;

  // opcode decoder, purely combinational on the offered word
  dfre_decode dfre_decode_inst (
    .instr_i (INSTR_I),
    .dec_o   (dec_w)
  );

  // a word is taken only in q1; a foreign word still walks all four phases
  // so the sequencer sees the same cycle length for every word
  assign take_w   = (phase_q == PH_Q1) && INSTR_VALID_I;
  // retire needs a matching word and the last phase
  assign retire_w = (phase_q == PH_Q4) && dec_q.hit;

  // phase sequencing: q1 waits for a word, then q2..q4 follow with no stall
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PH_Q1: begin
        // hold q1 until the sequencer offers a word
        if (INSTR_VALID_I) begin
          phase_d = PH_Q2;
        end
      end
      PH_Q2: phase_d = PH_Q3;
      PH_Q3: phase_d = PH_Q4;
      PH_Q4: phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
  end

  // phase register
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  // decode latch and read request; the strobe stands during q2 only
  // a foreign word raises no strobe, so the file sees no stray read
  always_comb begin
    dec_d   = dec_q;
    re_d    = 1'b0;
    raddr_d = raddr_q;
    if (take_w) begin
      dec_d   = dec_w;
      re_d    = dec_w.hit;
      raddr_d = dec_w.addr;
    end else if (phase_q == PH_Q1) begin
      // idle q1 drops the old word so it can never retire twice
      dec_d = '0;
    end
  end

  // decode registers; the read address holds until the next word is taken
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      dec_q   <= '0;
      re_q    <= 1'b0;
      raddr_q <= 7'h00;
    end else begin
      dec_q   <= dec_d;
      re_q    <= re_d;
      raddr_q <= raddr_d;
    end
  end

  // operand capture in q2, decrement in q3
  always_comb begin
    opnd_d = opnd_q;
    res_d  = res_q;
    case (phase_q)
      PH_Q2: begin
        // memory answers in the same cycle as the strobe
        opnd_d = FILE_RDATA_I;
      end
      PH_Q3: begin
        // plain 8-bit subtract wraps 00 to ff; no borrow is kept
        res_d = opnd_q - ONE_BYTE;
      end
      default: begin
        opnd_d = opnd_q;
        res_d  = res_q;
      end
    endcase
  end

  // datapath registers
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      opnd_q <= 8'h00;
      res_q  <= 8'h00;
    end else begin
      opnd_q <= opnd_d;
      res_q  <= res_d;
    end
  end

  // destination write in q4; exactly one of the two destinations moves
  always_comb begin
    w_d  = w_q;
    wr_d = '0;
    if (retire_w) begin
      if (dec_q.dest_f) begin
        wr_d.we   = 1'b1;
        wr_d.addr = dec_q.addr;
        wr_d.data = res_q;
      end else begin
        w_d = res_q;
      end
    end
  end

  // destination registers; the write strobe lasts a single cycle
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      w_q  <= W_RESET;
      wr_q <= '0;
    end else begin
      w_q  <= w_d;
      wr_q <= wr_d;
    end
  end

  // zero flag and retire pulse; no other status bit is driven from here
  always_comb begin
    z_d    = z_q;
    zwe_d  = 1'b0;
    done_d = 1'b0;
    if (retire_w) begin
      z_d    = (res_q == ZERO_BYTE);
      zwe_d  = 1'b1;
      done_d = 1'b1;
    end
  end

  // status registers
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      z_q    <= 1'b0;
      zwe_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      z_q    <= z_d;
      zwe_q  <= zwe_d;
      done_q <= done_d;
    end
  end

  // output mapping; every output is a register
  // so the far side never sees decode glitches
  assign FILE_RADDR_O = raddr_q;
  assign FILE_RE_O    = re_q;
  assign FILE_WE_O    = wr_q.we;
  assign FILE_WADDR_O = wr_q.addr;
  assign FILE_WDATA_O = wr_q.data;
  assign W_O          = w_q;
  assign ZERO_FLAG_O  = z_q;
  assign ZERO_WE_O    = zwe_q;
  assign PHASE_O      = phase_q;
  assign DONE_O       = done_q;
endmodule
`default_nettype wire

// ### design/dfre_pkg.sv
// package for the decrement-file-register execution block
// assumes a single 50 MHz core clock and a four-phase instruction cycle
`default_nettype none
package dfre_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam logic [13:0] OP_MASK       = 14'h3f00;
  localparam logic [13:0] OP_MATCH      = 14'h0300;
  localparam int unsigned DEST_BIT      = 7;
  localparam int unsigned ADDR_MSB      = 6;
  localparam logic [7:0]  W_RESET       = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  ONE_BYTE      = 8'h01;

  // phase of the instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } dfre_phase_type;

  // decoded instruction fields
  typedef struct packed {
    logic       hit;
    logic       dest_f;
    logic [6:0] addr;
  } dfre_dec_type;

  // file memory write request
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } dfre_wr_type;
endpackage
`default_nettype wire

// ### design/dfre_decode.sv
// combinational decoder for the decrement-file opcode
// assumes the instruction word is stable while it is decoded
`timescale 1ns/1ps
`default_nettype none
module dfre_decode
  import dfre_pkg::*;
(
  // instruction in
  input  wire logic [13:0] instr_i,
  // decoded fields out
  output var dfre_dec_type dec_o
);
  // opcode compare and field split
  always_comb begin
    dec_o.hit    = ((instr_i & OP_MASK) == OP_MATCH);
    dec_o.dest_f = instr_i[DEST_BIT];
    dec_o.addr   = instr_i[ADDR_MSB:0];
  end
endmodule
`default_nettype wire

// ### dv/dfre_exec_assertions.sv
// checker for the decrement-file execution block
// assumes it is bound to dfre_exec and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dfre_exec_chk
  import dfre_pkg::*;
(
  // clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        RST_I,
  // sequencer side
  input wire logic        INSTR_VALID_I,
  input wire logic [13:0] INSTR_I,
  // file memory side
  input wire logic [7:0]  FILE_RDATA_I,
  input wire logic [6:0]  FILE_RADDR_O,
  input wire logic        FILE_RE_O,
  input wire logic        FILE_WE_O,
  input wire logic [6:0]  FILE_WADDR_O,
  input wire logic [7:0]  FILE_WDATA_O,
  // accumulator, status and sequencing
  input wire logic [7:0]  W_O,
  input wire logic        ZERO_FLAG_O,
  input wire logic        ZERO_WE_O,
  input wire logic [1:0]  PHASE_O,
  input wire logic        DONE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // word accepted in q1
  wire logic       hit = PHASE_O == 2'h0 && INSTR_VALID_I && (INSTR_I & OP_MASK) == OP_MATCH;
  wire logic [6:0] fa  = INSTR_I[6:0];
  sequence s_tk_f; hit && INSTR_I[DEST_BIT]; endsequence
  sequence s_tk_w; hit && !INSTR_I[DEST_BIT]; endsequence
  property p_re; hit |=> FILE_RE_O && FILE_RADDR_O == $past(fa); endproperty
  property p_f; s_tk_f |=> ##3 FILE_WE_O && $stable(W_O) && FILE_WADDR_O == $past(fa, 4)
    && FILE_WDATA_O == $past(FILE_RDATA_I, 3) - 8'h01; endproperty
  property p_w; s_tk_w |=> ##3 !FILE_WE_O && W_O == $past(FILE_RDATA_I, 3) - 8'h01; endproperty
  property p_done; hit |-> ##4 DONE_O && ZERO_WE_O; endproperty
  property p_miss; PHASE_O == 2'h0 && !hit |=> ##3 !DONE_O && !FILE_WE_O; endproperty
  property p_z; DONE_O |-> ZERO_FLAG_O == ((FILE_WE_O ? FILE_WDATA_O : W_O) == 8'h00); endproperty
  property p_ph; PHASE_O != 2'h0 |=> PHASE_O == $past(PHASE_O) + 2'h1; endproperty
  property p_wst; $changed(W_O) |-> DONE_O; endproperty
  a_re: assert property (p_re) else $error("read strobe or address wrong");
  a_f: assert property (p_f) else $error("file write-back wrong");
  a_w: assert property (p_w) else $error("accumulator result wrong");
  a_done: assert property (p_done) else $error("retire not in one cycle");
  a_miss: assert property (p_miss) else $error("foreign word had effect");
  a_z: assert property (p_z) else $error("zero flag wrong");
  a_ph: assert property (p_ph) else $error("phase order wrong");
  a_wst: assert property (p_wst) else $error("accumulator changed off retire");
endmodule
bind dfre_exec dfre_exec_chk dfre_exec_chk_inst (
  .CLK_SYS_I     (CLK_SYS_I),
  .RST_I         (RST_I),
  .INSTR_VALID_I (INSTR_VALID_I),
  .INSTR_I       (INSTR_I),
  .FILE_RDATA_I  (FILE_RDATA_I),
  .FILE_RADDR_O  (FILE_RADDR_O),
  .FILE_RE_O     (FILE_RE_O),
  .FILE_WE_O     (FILE_WE_O),
  .FILE_WADDR_O  (FILE_WADDR_O),
  .FILE_WDATA_O  (FILE_WDATA_O),
  .W_O           (W_O),
  .ZERO_FLAG_O   (ZERO_FLAG_O),
  .ZERO_WE_O     (ZERO_WE_O),
  .PHASE_O       (PHASE_O),
  .DONE_O        (DONE_O)
);
`default_nettype wire

// ### dv/dfre_file_mem.sv
// data file memory model facing the execution block
// assumes combinational read and a write on the clock edge
`timescale 1ns/1ps
`default_nettype none
module dfre_file_mem (
  // clock
  input  wire logic       clk_i,
  // read port
  input  wire logic       re_i,
  input  wire logic [6:0] raddr_i,
  // write port
  input  wire logic       we_i,
  input  wire logic [6:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  // read data
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [128];
  // unselected reads show the inverse so stale data never passes
  assign rdata_o = re_i ? mem[raddr_i] : ~mem[raddr_i];
  // plain always so the bench may preload the array
  always @(posedge clk_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule
`default_nettype wire

// ### dv/dfre_exec_bench.sv
// self-checking bench for the decrement-file execution block
// assumes the file memory model and checker sit beside the design
`timescale 1ns/1ps
`default_nettype none
module dfre_exec_bench;
  import dfre_pkg::*;
  logic        CLK_SYS_I = 0, RST_I = 1, INSTR_VALID_I = 0;
  logic [13:0] INSTR_I = '0, mw;
  logic [7:0]  FILE_RDATA_I, FILE_WDATA_O, W_O, sh [128];
  logic [6:0]  FILE_RADDR_O, FILE_WADDR_O;
  logic        FILE_RE_O, FILE_WE_O, ZERO_FLAG_O, ZERO_WE_O, DONE_O;
  logic [1:0]  PHASE_O;
  logic [16:0] notes [$];
  logic [16:0] got;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  always #10 CLK_SYS_I = ~CLK_SYS_I;
  dfre_exec dfre_exec_inst (
    .CLK_SYS_I     (CLK_SYS_I),
    .RST_I         (RST_I),
    .INSTR_VALID_I (INSTR_VALID_I),
    .INSTR_I       (INSTR_I),
    .FILE_RDATA_I  (FILE_RDATA_I),
    .FILE_RADDR_O  (FILE_RADDR_O),
    .FILE_RE_O     (FILE_RE_O),
    .FILE_WE_O     (FILE_WE_O),
    .FILE_WADDR_O  (FILE_WADDR_O),
    .FILE_WDATA_O  (FILE_WDATA_O),
    .W_O           (W_O),
    .ZERO_FLAG_O   (ZERO_FLAG_O),
    .ZERO_WE_O     (ZERO_WE_O),
    .PHASE_O       (PHASE_O),
    .DONE_O        (DONE_O)
  );
  dfre_file_mem dfre_file_mem_inst (.clk_i(CLK_SYS_I), .re_i(FILE_RE_O), .we_i(FILE_WE_O),
    .raddr_i(FILE_RADDR_O), .waddr_i(FILE_WADDR_O), .wdata_i(FILE_WDATA_O),
    .rdata_o(FILE_RDATA_I));
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // note the expected retire, then offer the word for one q1
  task automatic issue(input logic [13:0] wd);
    logic [7:0] v;
    v = sh[wd[6:0]] - 8'h01;
    if ((wd & OP_MASK) == OP_MATCH) begin
      notes.push_back({wd[7], wd[7] ? wd[6:0] : 7'h00, v, v == 8'h00});
      if (wd[7]) sh[wd[6:0]] = v;
    end
    INSTR_VALID_I = 1;
    INSTR_I = wd;
    @(posedge CLK_SYS_I) #1 INSTR_VALID_I = 0;
    repeat (3) @(posedge CLK_SYS_I);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watcher: each retire takes the oldest note
  always @(posedge CLK_SYS_I) begin
    #2;
    got = FILE_WE_O ? {1'b1, FILE_WADDR_O, FILE_WDATA_O, ZERO_FLAG_O}
      : {1'b0, 7'h00, W_O, ZERO_FLAG_O};
    if (DONE_O === 1'b1 && notes.size() == 0) chk(17'h1ffff, 17'h0);
    else if (DONE_O === 1'b1) chk(got, notes.pop_front());
    cyc++;
    if (cyc == 3000) n_errors++;
    if (cyc == 3000) test_done();
  end
  initial begin
    void'($urandom(32'h43c2ac31));
    // low addresses hold 0..3 so wrap and zero results occur
    for (int i = 0; i < 128; i++) sh[i] = (i < 4) ? 8'(i) : 8'($urandom);
    for (int i = 0; i < 128; i++) dfre_file_mem_inst.mem[i] = sh[i];
    repeat (3) @(posedge CLK_SYS_I);
    #1 RST_I = 0;
    for (int k = 0; k < 60; k++)
      issue({6'h03, 1'($urandom), (k < 12) ? 7'(k % 4) : (k == 12) ? 7'h7f : 7'($urandom)});
    $display("hits done");
    // foreign words interleaved with hits, back to back
    for (int k = 0; k < 20; k++) begin
      mw = 14'($urandom);
      if ((mw & OP_MASK) == OP_MATCH) mw = mw ^ 14'h0100;
      issue(mw);
      issue({6'h03, 1'($urandom), 7'($urandom)});
    end
    repeat (2) @(posedge CLK_SYS_I);
    chk(17'(notes.size()), 17'h0);
    $display("misses done");
    test_done();
  end
endmodule
`default_nettype wire
